// ===== adcs_defines.svh
// Purpose: offsets, field positions and reset values of the calibration/mode sequencer
// Assumes: one 32-bit aligned word per register on AXI4-Lite
// Notes: byte address is four times the register index
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH

// =====================================================================
// register indices and byte addresses
`define ADCS_IDX_COMM 3'h0
`define ADCS_IDX_MODE 3'h1
`define ADCS_IDX_DATA 3'h5
`define ADCS_ADDR_COMM 8'h00
`define ADCS_ADDR_MODE 8'h04
`define ADCS_ADDR_DATA 8'h14

// =====================================================================
// mode register fields
`define ADCS_MODE_OP_HI 7
`define ADCS_MODE_OP_LO 5
`define ADCS_MODE_GAIN_HI 4
`define ADCS_MODE_GAIN_LO 2
`define ADCS_MODE_TEST_CUR 1
`define ADCS_MODE_FSYNC 0
`define ADCS_MODE_RESET 8'h00

// =====================================================================
// communications register fields
`define ADCS_COMM_READY_BIT 7
`define ADCS_COMM_CHAN_HI 2
`define ADCS_COMM_CHAN_LO 0
`define ADCS_CHAN_RESET 3'h4

// =====================================================================
// data register and bus answers
`define ADCS_DATA_W 24
`define ADCS_DATA_RESET 24'h000000
`define ADCS_RESP_OKAY 2'h0
`define ADCS_RESP_SLVERR 2'h2

`endif

// ===== adcs_pkg.sv
// Purpose: types shared by the sequencer files
// Assumes: nothing
// Notes: codes 101..111 are not sequenced here
package adcs_pkg;

    // =================================================================
    // operating-mode codes
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0,
        MODE_SELF = 3'h1,
        MODE_SYS_ZERO = 3'h2,
        MODE_SYS_FULL = 3'h3,
        MODE_SYS_OFFSET = 3'h4
    } adcs_mode_e;

    // =================================================================
    // calibration signal source
    typedef enum logic [1:0] {
        SRC_SHORT = 2'h0,
        SRC_AIN = 2'h1,
        SRC_REF = 2'h2
    } adcs_src_e;

    // =================================================================
    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ZERO = 2'h1,
        ST_FULL = 2'h2
    } adcs_state_e;

endpackage

// ===== adcs_cal_seq.sv
// Purpose: one-shot calibration step sequencer
// Assumes: step_done is a one-cycle pulse from the converter datapath on aclk
// Notes: done_q pulses in the cycle the sequencer returns to idle
`timescale 1ns/1ns
`default_nettype none

module adcs_cal_seq (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic start,
    input wire logic [2:0] code,
    input wire logic step_done,
    // status and datapath steering
    output logic busy_q,
    output logic done_q,
    output logic cal_req_q,
    output logic cal_full_q,
    output var adcs_pkg::adcs_src_e cal_src_q
);

    adcs_pkg::adcs_state_e state_q;
    adcs_pkg::adcs_mode_e code_q;

    // =================================================================
    // step selection
    wire logic is_self = (code == adcs_pkg::MODE_SELF);
    wire logic is_zsys = (code == adcs_pkg::MODE_SYS_ZERO);
    wire logic is_fsys = (code == adcs_pkg::MODE_SYS_FULL);
    wire logic is_ofs = (code == adcs_pkg::MODE_SYS_OFFSET);
    wire logic two_step = (code_q == adcs_pkg::MODE_SELF) || (code_q == adcs_pkg::MODE_SYS_OFFSET);
    wire logic go = start && (state_q == adcs_pkg::ST_IDLE) && (is_self || is_zsys || is_fsys || is_ofs);

    // =================================================================
    // state machine
    always_ff @(posedge aclk) begin
        done_q <= 1'b0;
        if (!aresetn) begin
            state_q <= adcs_pkg::ST_IDLE;
            code_q <= adcs_pkg::MODE_NORMAL;
            cal_req_q <= 1'b0;
            cal_full_q <= 1'b0;
            cal_src_q <= adcs_pkg::SRC_SHORT;
        end else begin
            unique case (state_q)
                adcs_pkg::ST_IDLE: begin
                    if (go) begin
                        code_q <= adcs_pkg::adcs_mode_e'(code);
                        cal_req_q <= 1'b1;
                        if (is_fsys) begin
                            state_q <= adcs_pkg::ST_FULL; // R7
                            cal_full_q <= 1'b1;
                            cal_src_q <= adcs_pkg::SRC_AIN;
                        end else begin
                            state_q <= adcs_pkg::ST_ZERO; // R3 R6 R8
                            cal_full_q <= 1'b0;
                            cal_src_q <= is_self ? adcs_pkg::SRC_SHORT : adcs_pkg::SRC_AIN;
                        end
                    end
                end
                adcs_pkg::ST_ZERO: begin
                    if (step_done && two_step) begin
                        state_q <= adcs_pkg::ST_FULL; // R3 R8
                        cal_full_q <= 1'b1;
                        cal_src_q <= adcs_pkg::SRC_REF;
                    end else if (step_done) begin
                        state_q <= adcs_pkg::ST_IDLE;
                        cal_req_q <= 1'b0;
                        done_q <= 1'b1;
                    end
                end
                adcs_pkg::ST_FULL: begin
                    if (step_done) begin
                        state_q <= adcs_pkg::ST_IDLE;
                        cal_req_q <= 1'b0;
                        done_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= adcs_pkg::ST_IDLE;
                    cal_req_q <= 1'b0;
                end
            endcase
        end
    end

    assign busy_q = (state_q != adcs_pkg::ST_IDLE);

    // =================================================================
    // checks
    sequence s_go(logic [2:0] c);
        start && !busy_q && code == c;
    endsequence

    sequence s_zero_step(adcs_pkg::adcs_src_e s);
        cal_req_q && !cal_full_q && cal_src_q == s;
    endsequence

    sequence s_ref_step;
        cal_req_q && cal_full_q && cal_src_q == adcs_pkg::SRC_REF;
    endsequence

    a_self_order: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        s_go(3'h1) |=> s_zero_step(adcs_pkg::SRC_SHORT))
        else $error("self calibration zero step misdirected");
    a_self_second: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        step_done && state_q == adcs_pkg::ST_ZERO && code_q == adcs_pkg::MODE_SELF |=> s_ref_step)
        else $error("self calibration full step misdirected");
    a_sys_zero: assert property (@(posedge aclk) disable iff (!aresetn) // R6
        s_go(3'h2) |=> !cal_full_q && cal_src_q == adcs_pkg::SRC_AIN && busy_q)
        else $error("zero-scale system calibration misdirected");
    a_sys_full: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        s_go(3'h3) |=> cal_full_q && cal_src_q == adcs_pkg::SRC_AIN && busy_q)
        else $error("full-scale system calibration misdirected");
    a_ofs_steps: assert property (@(posedge aclk) disable iff (!aresetn) // R8
        s_go(3'h4) |=> s_zero_step(adcs_pkg::SRC_AIN))
        else $error("system offset zero step misdirected");
    a_ofs_second: assert property (@(posedge aclk) disable iff (!aresetn) // R8
        step_done && state_q == adcs_pkg::ST_ZERO && code_q == adcs_pkg::MODE_SYS_OFFSET |=> s_ref_step)
        else $error("system offset full step misdirected");

endmodule

`default_nettype wire

// ===== adcs_mode_ctrl.sv
// Purpose: mode/calibration control block of a sigma-delta converter, AXI4-Lite slave
// Assumes: conversion words and step completion come from datapath logic on aclk
// Notes: comm at 0x00, mode at 0x04, data at 0x14 for reads only; data writes and other addresses answer SLVERR
//
// Contract
// R1 - mode: op mode, gain, test current, sync
// R2 - mode code zero is normal, reset value
// R3 - code 001: shorted zero, then reference full
// R4 - finished calibration clears mode field to zero
// R5 - ready_n high at start, low on new word
// R6 - code 010: zero scale from analog input
// R7 - code 011: full scale from analog input
// R8 - code 100: input zero, reference full scale
// R9 - 3-bit channel field, resets to 100
// R10 - comm read top bit mirrors ready_n
// R11 - cal code write starts; results withheld meanwhile
`timescale 1ns/1ns
`default_nettype none
`include "adcs_defines.svh"

module adcs_mode_ctrl (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // converter datapath
    input wire logic conv_valid,
    input wire logic [23:0] conv_data,
    input wire logic step_done,
    output logic conv_run,
    output logic cal_req,
    output logic cal_full,
    output var adcs_pkg::adcs_src_e cal_src,
    output logic [2:0] input_select,
    output logic [2:0] gain_sel,
    output logic test_current_on,
    output logic filter_hold_sync,
    // ready pin
    output logic result_ready_n
);

    logic [7:0] mode_q;
    logic [2:0] chan_q;
    logic [23:0] data_q;
    logic ready_n_q;
    logic aw_held_q, w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic rd_comm_q;
    logic busy, seq_done;

    // =================================================================
    // write decode
    wire logic wr_fire = aw_held_q && w_held_q && !bvalid;
    wire logic wr_comm = wr_fire && (awaddr_q == `ADCS_ADDR_COMM);
    wire logic wr_mode = wr_fire && (awaddr_q == `ADCS_ADDR_MODE);
    wire logic wr_ok = wr_comm || wr_mode;
    wire logic lane0 = wstrb_q[0];
    // a zero in the top bit is what lets a comm write take effect
    wire logic comm_take = wr_comm && lane0 && !wdata_q[`ADCS_COMM_READY_BIT];
    // writes to the mode register are refused while a calibration owns it
    wire logic mode_take = wr_mode && lane0 && !busy && !seq_done;
    wire logic [2:0] new_op = wdata_q[`ADCS_MODE_OP_HI:`ADCS_MODE_OP_LO];
    wire logic cal_code = (new_op != adcs_pkg::MODE_NORMAL) && (new_op <= adcs_pkg::MODE_SYS_OFFSET);
    wire logic cal_start = mode_take && cal_code;

    // =================================================================
    // read decode
    wire logic ar_fire = arvalid && arready;
    wire logic rd_comm = (araddr == `ADCS_ADDR_COMM);
    wire logic rd_mode = (araddr == `ADCS_ADDR_MODE);
    wire logic rd_data = (araddr == `ADCS_ADDR_DATA);
    wire logic [31:0] comm_word = {24'h000000, ready_n_q, 4'h0, chan_q};
    wire logic [31:0] rd_mux = rd_comm ? comm_word
                              : rd_mode ? {24'h000000, mode_q}
                              : rd_data ? {8'h00, data_q} : 32'h00000000;
    wire logic [1:0] rd_resp = (rd_comm || rd_mode || rd_data) ? `ADCS_RESP_OKAY : `ADCS_RESP_SLVERR;

    // =================================================================
    // result path: words are dropped while a calibration is running
    wire logic conv_load = conv_valid && !busy; // R11
    wire logic data_read = ar_fire && rd_data;

    // =================================================================
    // write channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `ADCS_RESP_OKAY;
            awready <= 1'b1;
            wready <= 1'b1;
        end else begin
            if (awvalid && awready) begin
                aw_held_q <= 1'b1;
                awready <= 1'b0;
                awaddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_held_q <= 1'b1;
                wready <= 1'b0;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp <= wr_ok ? `ADCS_RESP_OKAY : `ADCS_RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // =================================================================
    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `ADCS_RESP_OKAY;
            rd_comm_q <= 1'b0;
            arready <= 1'b1;
        end else if (ar_fire) begin
            rvalid <= 1'b1;
            arready <= 1'b0;
            rdata <= rd_mux; // R10
            rresp <= rd_resp;
            rd_comm_q <= rd_comm;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // =================================================================
    // mode and communications registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= `ADCS_MODE_RESET; // R2
            chan_q <= `ADCS_CHAN_RESET; // R9
        end else begin
            if (mode_take) begin
                mode_q <= wdata_q[7:0]; // R1 R11
            end else if (seq_done) begin
                mode_q[`ADCS_MODE_OP_HI:`ADCS_MODE_OP_LO] <= adcs_pkg::MODE_NORMAL; // R4
            end
            if (comm_take) begin
                chan_q <= wdata_q[`ADCS_COMM_CHAN_HI:`ADCS_COMM_CHAN_LO]; // R9
            end
        end
    end

    // =================================================================
    // data register and ready flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_q <= `ADCS_DATA_RESET;
            ready_n_q <= 1'b1;
            conv_run <= 1'b1;
        end else begin
            if (conv_load) begin
                data_q <= conv_data;
            end
            // conversions pause from the start edge until the sequencer reports done
            if (cal_start) begin
                conv_run <= 1'b0; // R11
            end else if (seq_done) begin
                conv_run <= 1'b1; // R4
            end
            // start beats a new word, a new word beats the read that retires the old one
            if (cal_start) begin
                ready_n_q <= 1'b1; // R5
            end else if (conv_load) begin
                ready_n_q <= 1'b0; // R5
            end else if (data_read) begin
                ready_n_q <= 1'b1;
            end
        end
    end

    // =================================================================
    // calibration sequencer
    adcs_cal_seq u_seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(cal_start),
        .code(new_op),
        .step_done(step_done),
        .busy_q(busy),
        .done_q(seq_done),
        .cal_req_q(cal_req),
        .cal_full_q(cal_full),
        .cal_src_q(cal_src)
    );

    assign result_ready_n = ready_n_q;
    assign input_select = chan_q;
    assign gain_sel = mode_q[`ADCS_MODE_GAIN_HI:`ADCS_MODE_GAIN_LO];
    assign test_current_on = mode_q[`ADCS_MODE_TEST_CUR];
    assign filter_hold_sync = mode_q[`ADCS_MODE_FSYNC];

    // =================================================================
    // checks
    sequence s_started;
        cal_start;
    endsequence

    a_reset_values: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        $rose(aresetn) |-> mode_q == `ADCS_MODE_RESET && chan_q == `ADCS_CHAN_RESET)
        else $error("mode or channel wrong after reset");
    a_mode_fields: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        mode_take |=> gain_sel == $past(wdata_q[4:2]) && test_current_on == $past(wdata_q[1])
            && filter_hold_sync == $past(wdata_q[0]))
        else $error("mode fields misplaced");
    a_mode_clear: assert property (@(posedge aclk) disable iff (!aresetn) // R4
        seq_done |=> mode_q[7:5] == 3'h0 && !busy)
        else $error("mode field not cleared after calibration");
    a_ready_start: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        s_started |=> result_ready_n && busy)
        else $error("ready not raised at calibration start");
    a_ready_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        busy && result_ready_n |=> result_ready_n)
        else $error("ready fell during calibration");
    a_ready_word: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        conv_valid && !busy && !cal_start |=> !result_ready_n && data_q == $past(conv_data))
        else $error("new word did not lower ready");
    a_comm_mirror: assert property (@(posedge aclk) disable iff (!aresetn) // R10
        $rose(rvalid) && rd_comm_q |-> rdata[7] == $past(result_ready_n))
        else $error("comm read does not mirror ready");
    a_withheld: assert property (@(posedge aclk) disable iff (!aresetn) // R11
        busy |=> $stable(data_q))
        else $error("result updated during calibration");

endmodule

`default_nettype wire

// ===== adcs_dp_model.sv
// Purpose: converter datapath stand-in facing the mode sequencer
// Assumes: sequencer outputs are registered on aclk
// Notes: slow stretches every calibration step
`timescale 1ns/1ns
`default_nettype none

module adcs_dp_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // sequencer side
    input wire logic conv_run,
    input wire logic cal_req,
    input wire logic slow,
    // datapath answers
    output logic conv_valid,
    output logic [23:0] conv_data,
    output logic step_done,
    output logic [23:0] last_q
);
    // =================================================================
    // step timer and word generator
    logic [5:0] conv_q;
    logic [3:0] step_q;
    wire [23:0] next_word = last_q + 24'h123457;

    always_ff @(posedge aclk) begin
        conv_valid <= 1'b0;
        step_done <= 1'b0;
        // off-pulse data is inverted so a stale sample cannot pass
        conv_data <= ~last_q;
        if (!aresetn) begin
            conv_q <= 6'h00;
            step_q <= 4'h0;
            last_q <= 24'h5a5a5a;
        end else begin
            step_q <= (cal_req && !step_done) ? step_q + 4'h1 : 4'h0;
            if (cal_req && !step_done && step_q == (slow ? 4'he : 4'h1)) begin
                step_done <= 1'b1;
                step_q <= 4'h0;
            end
            conv_q <= conv_run ? conv_q + 6'h01 : 6'h00;
            if (conv_run && conv_q == 6'h3f) begin
                conv_valid <= 1'b1;
                conv_data <= next_word;
                last_q <= next_word;
            end
        end
    end
endmodule
`default_nettype wire

// ===== adcs_mode_ctrl_tb_top.sv
// Purpose: self-checking bench for the mode and calibration sequencer
// Assumes: one bus transfer at a time, responses checked from a queue
// Notes: datapath model gives prompt steps for even codes, slow for odd
`timescale 1ns/1ns
`default_nettype none
`include "adcs_defines.svh"

module adcs_mode_ctrl_tb_top;
    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } adcs_exp_s;
    // =================================================================
    // signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic slow = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, conv_valid, step_done, conv_run;
    logic cal_req, cal_full, test_current_on, filter_hold_sync, result_ready_n;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [23:0] conv_data, last_word;
    logic [2:0] input_select, gain_sel;
    adcs_pkg::adcs_src_e cal_src;
    int mismatches = 0, n_compared = 0, cycles = 0;
    integer seed = 32'haa933c7b;
    adcs_exp_s exp_q[$];
    adcs_exp_s e;

    always #20 aclk = ~aclk;

    adcs_mode_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .conv_valid(conv_valid), .conv_data(conv_data), .step_done(step_done), .conv_run(conv_run),
        .cal_req(cal_req), .cal_full(cal_full), .cal_src(cal_src), .input_select(input_select),
        .gain_sel(gain_sel), .test_current_on(test_current_on), .filter_hold_sync(filter_hold_sync),
        .result_ready_n(result_ready_n));

    adcs_dp_model u_dp (.aclk(aclk), .aresetn(aresetn), .conv_run(conv_run), .cal_req(cal_req),
        .slow(slow), .conv_valid(conv_valid), .conv_data(conv_data), .step_done(step_done),
        .last_q(last_word));

    // =================================================================
    // checking and closing
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            $display("Error at %0t: run too long", $time);
            final_report();
        end
    end

    // responses are taken from the queue in issue order
    always @(posedge aclk) begin
        if ((bvalid && bready) || (rvalid && rready)) begin
            if (exp_q.size() == 0) begin
                cmp(32'h1, 32'h0, "unexpected response");
            end else begin
                e = exp_q.pop_front();
                cmp({30'h0, (bvalid && bready) ? bresp : rresp}, {30'h0, e.resp}, "response");
                if (rvalid && e.resp === `ADCS_RESP_OKAY) cmp(rdata, e.data, "read data");
            end
        end
    end

    // =================================================================
    // bus master
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_t, w_t, b_t;
        exp_q.push_back('{d, r});
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_t = 1'b0;
        while (!b_t) begin
            @(negedge aclk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid && bready;
            @(posedge aclk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ar_t, r_t;
        exp_q.push_back('{d, r});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_t = 1'b0;
        while (!r_t) begin
            @(negedge aclk);
            ar_t = arvalid && arready;
            r_t = rvalid && rready;
            @(posedge aclk);
            if (ar_t) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    // sel 0 step pulse, 1 busy, 2 ready pin
    task automatic wait_for(input int sel, input logic lvl);
        logic v;
        for (int i = 0; i < 300; i++) begin
            @(posedge aclk);
            #1;
            v = (sel == 0) ? step_done : (sel == 1) ? cal_req : result_ready_n;
            if (v === lvl) return;
        end
        cmp(32'h1, 32'h0, "wait limit");
    endtask

    // t holds {two steps, second {full, src}, first {full, src}}
    task automatic run_cal(input logic [2:0] code, input logic [6:0] t);
        logic [7:0] mv;
        mv = {code, 5'($random(seed))};
        slow <= code[0];
        axi_write(`ADCS_ADDR_MODE, {24'h0, mv}, `ADCS_RESP_OKAY);
        #1;
        cmp(32'({cal_req, conv_run}), 32'h2, "busy, conversions held");
        cmp(32'(result_ready_n), 32'h1, "ready_n at start");
        cmp(32'({cal_full, cal_src}), 32'(t[2:0]), "first step");
        cmp(32'(gain_sel), 32'(mv[4:2]), "gain");
        if (code[0]) begin
            axi_write(`ADCS_ADDR_MODE, 32'h0, `ADCS_RESP_OKAY);
            axi_read(`ADCS_ADDR_MODE, {24'h0, mv}, `ADCS_RESP_OKAY);
        end
        if (t[6]) begin
            wait_for(0, 1'b1);
            @(posedge aclk);
            #1;
            cmp(32'({cal_req, cal_full, cal_src}), 32'({1'b1, t[5:3]}), "second step");
        end
        wait_for(1, 1'b0);
        repeat (2) @(posedge aclk);
        axi_read(`ADCS_ADDR_MODE, {24'h0, 3'h0, mv[4:0]}, `ADCS_RESP_OKAY);
        wait_for(2, 1'b0);
        axi_read(`ADCS_ADDR_DATA, {8'h0, last_word}, `ADCS_RESP_OKAY);
        axi_read(`ADCS_ADDR_COMM, 32'h82, `ADCS_RESP_OKAY);
    endtask

    // =================================================================
    // main sequence
    initial begin
        logic [7:0] mv;
        logic [6:0] tab [1:4];
        tab[1] = 7'b1_110_000;
        tab[2] = 7'b0_000_001;
        tab[3] = 7'b0_000_101;
        tab[4] = 7'b1_110_001;
        mv = {3'h0, 5'($random(seed))};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`ADCS_ADDR_COMM, 32'h84, `ADCS_RESP_OKAY);
        axi_read(`ADCS_ADDR_MODE, 32'h0, `ADCS_RESP_OKAY);
        axi_write(`ADCS_ADDR_MODE, {24'h0, mv}, `ADCS_RESP_OKAY);
        axi_write(`ADCS_ADDR_COMM, 32'h02, `ADCS_RESP_OKAY);
        axi_write(`ADCS_ADDR_COMM, 32'h85, `ADCS_RESP_OKAY);
        axi_read(`ADCS_ADDR_MODE, {24'h0, mv}, `ADCS_RESP_OKAY);
        axi_read(`ADCS_ADDR_COMM, 32'h82, `ADCS_RESP_OKAY);
        cmp(32'({gain_sel, test_current_on, filter_hold_sync, input_select}), 32'({mv[4:0], 3'h2}), "fields");
        axi_write(`ADCS_ADDR_DATA, 32'h1, `ADCS_RESP_SLVERR);
        axi_write(8'h20, 32'h1, `ADCS_RESP_SLVERR);
        axi_read(8'h3c, 32'h0, `ADCS_RESP_SLVERR);
        axi_write(`ADCS_ADDR_MODE, 32'ha0, `ADCS_RESP_OKAY);
        #1;
        cmp(32'({cal_req, conv_run}), 32'h1, "reserved code starts nothing");
        axi_read(`ADCS_ADDR_MODE, 32'ha0, `ADCS_RESP_OKAY);
        wstrb <= 4'he;
        axi_write(`ADCS_ADDR_COMM, 32'h03, `ADCS_RESP_OKAY);
        wstrb <= 4'hf;
        wait_for(2, 1'b0);
        axi_read(`ADCS_ADDR_DATA, {8'h0, last_word}, `ADCS_RESP_OKAY);
        axi_read(`ADCS_ADDR_COMM, 32'h82, `ADCS_RESP_OKAY);
        for (int c = 1; c <= 4; c++) run_cal(3'(c), tab[c]);
        repeat (4) @(posedge aclk);
        final_report();
    end
endmodule
`default_nettype wire
